/* src/ssl_regs.vh */
// Constants for the late-write synchronous RAM port
`ifndef SSL_REGS_VH
`define SSL_REGS_VH
`define SSL_ADDR_W 8
`define SSL_LANE_W 9
`define SSL_LANES 4
`define SSL_DATA_W 36
`define SSL_DEPTH 256
`define SSL_FIFO_DEPTH 8
`define SSL_FIFO_AW 3
`define SSL_PIPE_LAT 2
`define SSL_FLOW_LAT 1
`define SSL_BURST_LEN 4
`endif

/* src/ssl_fifo.v */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ssl_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire sys_clk_in,
	input wire sys_rst_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output reg [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW:0] wr_ptr_reg;
	reg [AW:0] rd_ptr_reg;
	reg out_valid_reg;
	wire [AW:0] count;
	wire mem_empty;
	wire load_out;
	assign count = wr_ptr_reg - rd_ptr_reg;
	assign mem_empty = (count == {(AW+1){1'b0}});
	// Depth is a power of two, so the top count bit alone marks full
	assign in_ready_out = (count[AW] == 1'b0);
	assign out_valid_out = out_valid_reg;
	// Output register refills whenever it is empty or being drained
	assign load_out = !mem_empty && (!out_valid_reg || out_ready_in);
	always @(posedge sys_clk_in) begin
		if (in_valid_in && in_ready_out)
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
		if (load_out)
			out_data_out <= mem_reg[rd_ptr_reg[AW-1:0]];
	end
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
			out_valid_reg <= 1'b0;
		end else begin
			if (in_valid_in && in_ready_out)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (load_out) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				out_valid_reg <= 1'b1;
			end else if (out_ready_in) begin
				out_valid_reg <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* src/ssl_port.v */
// Synchronous late-write RAM command/data port with burst counter
//
// Contract
// - Sync inputs sampled on rising clock edge
// - Clock gate high freezes command, burst and read data state; queued writes still retire
// - Selected only when all three selects active
// - Read starts on selected load with write high
// - Pipeline read data driven one edge later
// - Write registers address, lanes at command edge
// - Each lane enable gates its lane
// - Write with no lanes modifies nothing
// - Pipeline write latency equals read, two cycles
// - Flow-through read data one cycle earlier
// - Flow-through write data at second edge
// - Flow-through activation and burst same as pipeline
// - Advance high steps the burst counter
// - Low address bits preset burst counter
// - Output enable high tristates drivers anytime
// - Sleep request high enters sleep mode
// - Order select low linear, high interleaved
// - Flow select low gives flow-through mode
// - Burst wraps after four addresses
// - Linear order increments low bits modulo four
// - Drivers off during write data cycles
`timescale 1ns/1ps
`default_nettype none
`include "ssl_regs.vh"
module ssl_port (
	input wire sys_clk_in,
	input wire sys_rst_in,
	input wire clock_gate_n_in,
	input wire select1_n_in,
	input wire select2_in,
	input wire select3_n_in,
	input wire write_n_in,
	input wire advance_load_in,
	input wire [`SSL_ADDR_W-1:0] addr_in,
	input wire [`SSL_LANES-1:0] lane_wr_n_in,
	input wire out_enable_n_in,
	input wire sleep_req_in,
	input wire linear_order_n_in,
	input wire flow_select_n_in,
	input wire [`SSL_DATA_W-1:0] data_in,
	output reg [`SSL_DATA_W-1:0] data_out,
	output reg [`SSL_LANES-1:0] data_oe_out,
	output reg sleeping_out,
	output reg wr_ready_out,
	output reg drop_out
);
	localparam ST_IDLE = 3'b001;
	localparam ST_READ = 3'b010;
	localparam ST_WRITE = 3'b100;

	// Active edge: sleep blocks the clock as well as the gate
	wire edge_en = !clock_gate_n_in && !sleep_req_in;
	wire selected = !select1_n_in && select2_in && !select3_n_in;
	wire load_cmd = edge_en && !advance_load_in;
	wire adv_cmd = edge_en && advance_load_in;
	wire flow = !flow_select_n_in;

	reg [2:0] burst_reg;
	reg [`SSL_ADDR_W-1:0] base_reg;
	reg [1:0] start_reg;
	reg [1:0] cnt_reg;
	reg [1:0] cnt_next;
	reg [2:0] next_state;
	reg [`SSL_ADDR_W-1:0] cmd_addr;
	reg cmd_rd;
	reg cmd_wr;

	// Burst address generation
	always @* begin
		next_state = burst_reg;
		cnt_next = cnt_reg;
		cmd_rd = 1'b0;
		cmd_wr = 1'b0;
		cmd_addr = base_reg;
		case (burst_reg)
		ST_IDLE, ST_READ, ST_WRITE: begin
			if (load_cmd) begin
				cnt_next = 2'b00;
				cmd_addr = addr_in;
				if (!selected) begin
					next_state = ST_IDLE;
				end else if (write_n_in) begin
					next_state = ST_READ;
					cmd_rd = 1'b1;
				end else begin
					next_state = ST_WRITE;
					cmd_wr = 1'b1;
				end
			end else if (adv_cmd && burst_reg != ST_IDLE) begin
				cnt_next = cnt_reg + 2'b01;
				if (linear_order_n_in)
					cmd_addr[1:0] = start_reg ^ cnt_next;
				else
					cmd_addr[1:0] = start_reg + cnt_next;
				cmd_rd = (burst_reg == ST_READ);
				cmd_wr = (burst_reg == ST_WRITE);
			end
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			burst_reg <= ST_IDLE;
			base_reg <= {`SSL_ADDR_W{1'b0}};
			start_reg <= 2'b00;
			cnt_reg <= 2'b00;
		end else if (edge_en) begin
			burst_reg <= next_state;
			cnt_reg <= cnt_next;
			if (load_cmd) begin
				base_reg <= addr_in;
				start_reg <= addr_in[1:0];
			end
		end
	end

	// Command pipeline: stage 1 is the edge after the command
	reg rd1_reg;
	reg wr1_reg;
	reg rd2_reg;
	reg wr2_reg;
	reg [`SSL_ADDR_W-1:0] a1_reg;
	reg [`SSL_ADDR_W-1:0] a2_reg;
	reg [`SSL_LANES-1:0] l1_reg;
	reg [`SSL_LANES-1:0] l2_reg;
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd1_reg <= 1'b0;
			wr1_reg <= 1'b0;
			rd2_reg <= 1'b0;
			wr2_reg <= 1'b0;
			a1_reg <= {`SSL_ADDR_W{1'b0}};
			a2_reg <= {`SSL_ADDR_W{1'b0}};
			l1_reg <= {`SSL_LANES{1'b1}};
			l2_reg <= {`SSL_LANES{1'b1}};
		end else if (edge_en) begin
			rd1_reg <= cmd_rd;
			wr1_reg <= cmd_wr;
			a1_reg <= cmd_addr;
			l1_reg <= lane_wr_n_in;
			rd2_reg <= rd1_reg;
			wr2_reg <= wr1_reg;
			a2_reg <= a1_reg;
			l2_reg <= l1_reg;
		end
	end

	// Write data arrives one edge (flow) or two edges (pipeline) late
	wire wr_due = flow ? wr1_reg : wr2_reg;
	wire [`SSL_ADDR_W-1:0] wr_addr = flow ? a1_reg : a2_reg;
	wire [`SSL_LANES-1:0] wr_lanes = flow ? l1_reg : l2_reg;
	wire wr_take = edge_en && wr_due;

	// Captured write words queue in front of the array
	localparam QW = `SSL_ADDR_W + `SSL_LANES + `SSL_DATA_W;
	wire q_in_ready;
	wire q_out_valid;
	wire [QW-1:0] q_out_data;
	ssl_fifo #(
		.WIDTH(QW),
		.DEPTH(`SSL_FIFO_DEPTH),
		.AW(`SSL_FIFO_AW)
	) u_wq (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.in_valid_in(wr_take),
		.in_ready_out(q_in_ready),
		.in_data_in({wr_addr, wr_lanes, data_in}),
		.out_valid_out(q_out_valid),
		.out_ready_in(1'b1),
		.out_data_out(q_out_data)
	);

	// Array: a queued write is retired every cycle, whether or not the port reads
	reg [`SSL_DATA_W-1:0] mem_reg [0:`SSL_DEPTH-1];
	wire [`SSL_ADDR_W-1:0] q_addr = q_out_data[QW-1:QW-`SSL_ADDR_W];
	wire [`SSL_LANES-1:0] q_lanes = q_out_data[QW-`SSL_ADDR_W-1:`SSL_DATA_W];
	wire [`SSL_DATA_W-1:0] q_data = q_out_data[`SSL_DATA_W-1:0];
	integer i;
	integer j;
	always @(posedge sys_clk_in) begin
		if (q_out_valid) begin
			for (i = 0; i < `SSL_LANES; i = i + 1) begin
				if (!q_lanes[i])
					mem_reg[q_addr][i*`SSL_LANE_W +: `SSL_LANE_W] <=
						q_data[i*`SSL_LANE_W +: `SSL_LANE_W];
			end
		end
	end

	// Read bypass: the write held at the queue output for the address wins
	reg [`SSL_DATA_W-1:0] rd_word;
	always @* begin
		rd_word = mem_reg[flow ? cmd_addr : a1_reg];
		if (q_out_valid && q_addr == (flow ? cmd_addr : a1_reg))
			for (j = 0; j < `SSL_LANES; j = j + 1)
				if (!q_lanes[j])
					rd_word[j*`SSL_LANE_W +: `SSL_LANE_W] =
						q_data[j*`SSL_LANE_W +: `SSL_LANE_W];
	end

	wire rd_due = flow ? cmd_rd : rd1_reg;
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			data_out <= {`SSL_DATA_W{1'b0}};
			data_oe_out <= {`SSL_LANES{1'b0}};
			sleeping_out <= 1'b0;
			wr_ready_out <= 1'b1;
			drop_out <= 1'b0;
		end else begin
			sleeping_out <= sleep_req_in;
			wr_ready_out <= q_in_ready;
			drop_out <= wr_take && !q_in_ready;
			if (sleep_req_in || out_enable_n_in) begin
				data_oe_out <= {`SSL_LANES{1'b0}};
			end else if (edge_en) begin
				if (rd_due) begin
					data_out <= rd_word;
					data_oe_out <= {`SSL_LANES{1'b1}};
				end else begin
					data_oe_out <= {`SSL_LANES{1'b0}};
				end
			end
		end
	end
endmodule
`default_nettype wire

/* tb/ssl_master.sv */
// Bus master model: commands and late write data
`timescale 1ns/1ps
`default_nettype none
module ssl_master (
	input wire logic clk_in,
	input wire logic flow_n_in,
	output logic gate_n_out = 1'b0,
	output logic [2:0] sel_out = 3'b110,
	output logic wr_n_out = 1'b1,
	output logic adv_out = 1'b0,
	output logic [7:0] addr_out = 8'h00,
	output logic [3:0] lanes_out = 4'hf,
	output logic [35:0] data_out = 36'h0
);
	logic [35:0] wd = 36'h0;
	logic [35:0] dly = 36'h0;
	// Gated edges freeze the data pipe just as they freeze the port's command pipeline
	always @(posedge clk_in) begin
		if (!gate_n_out) begin
			dly <= wd;
			data_out <= flow_n_in ? dly : wd;
		end
	end
	task automatic cmd(input logic g, input logic [2:0] s,
		input logic w_n, input logic ad, input logic [7:0] a,
		input logic [3:0] ln, input logic [35:0] d);
		@(posedge clk_in);
		gate_n_out <= g;
		sel_out <= s;
		wr_n_out <= w_n;
		adv_out <= ad;
		addr_out <= a;
		lanes_out <= ln;
		wd <= d;
	endtask
endmodule
`default_nettype wire

/* tb/ssl_port_asserts.sv */
// Assertions on the late-write RAM port outputs
`timescale 1ns/1ps
`default_nettype none
`include "ssl_regs.vh"
module ssl_port_asserts (
	input wire logic sys_clk_in, sys_rst_in, clock_gate_n_in,
	input wire logic select1_n_in, select2_in, select3_n_in,
	input wire logic write_n_in, advance_load_in,
	input wire logic [`SSL_ADDR_W-1:0] addr_in,
	input wire logic [`SSL_LANES-1:0] lane_wr_n_in, data_oe_out,
	input wire logic out_enable_n_in, sleep_req_in, linear_order_n_in,
	input wire logic flow_select_n_in, sleeping_out, wr_ready_out,
	input wire logic [`SSL_DATA_W-1:0] data_in, data_out,
	input wire logic drop_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire act = !clock_gate_n_in && !sleep_req_in && !out_enable_n_in;
	wire sel = !select1_n_in && select2_in && !select3_n_in;
	wire rd = act && sel && !advance_load_in && write_n_in;
	wire wr = act && sel && !advance_load_in && !write_n_in;
	wire ft = !flow_select_n_in;
	wire off = data_oe_out == 4'h0;
	wire on = data_oe_out == 4'hf;
	chk_pipe_read: assert property (
		rd && !ft ##1 act |=> on) else $error("pipe read idle");
	chk_flow_read: assert property (
		rd && ft |=> on) else $error("flow read idle");
	chk_pipe_write: assert property (
		wr && !ft ##1 act |=> off) else $error("pipe write drives");
	chk_flow_write: assert property (
		wr && ft |=> off) else $error("flow write drives");
	chk_desel_idle: assert property (
		act && !advance_load_in && !sel && ft |=> off)
		else $error("deselect drives");
	chk_gate_hold: assert property (
		clock_gate_n_in |=> $stable(data_out)) else $error("gate moved");
	chk_oe_off: assert property (
		out_enable_n_in |=> off) else $error("oe high drives");
	chk_sleep_off: assert property (
		sleep_req_in |=> off && sleeping_out) else $error("no sleep");
	chk_no_drop: assert property (
		!drop_out) else $error("write lost");
	chk_queue_room: assert property (
		wr_ready_out) else $error("queue full");
endmodule
bind ssl_port ssl_port_asserts chk_u (.sys_clk_in, .sys_rst_in,
	.clock_gate_n_in, .select1_n_in, .select2_in, .select3_n_in,
	.write_n_in, .advance_load_in, .addr_in, .lane_wr_n_in,
	.out_enable_n_in, .sleep_req_in, .linear_order_n_in,
	.flow_select_n_in, .data_in, .data_out, .data_oe_out,
	.sleeping_out, .wr_ready_out, .drop_out);
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the late-write RAM port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, oe_n = 1'b0;
	logic sleep = 1'b0, order_n = 1'b0, flow_n = 1'b1, seen = 1'b0;
	wire logic gate_n, wr_n, advance_load, slp, rdy, drop;
	wire logic [2:0] s;
	wire logic [7:0] addr;
	wire logic [3:0] ln, oe;
	wire logic [35:0] wd, rd;
	logic [35:0] mem_ref [256];
	logic [35:0] exp_q [$];
	logic [2:0] ds [3] = '{3'b110, 3'b000, 3'b011};
	int num_errors = 0, tests_run = 0;
	integer seed = 32'hb243;
	always #5 sys_clk_in = ~sys_clk_in;
	ssl_master mst_u (.clk_in(sys_clk_in), .flow_n_in(flow_n),
		.gate_n_out(gate_n), .sel_out(s), .wr_n_out(wr_n),
		.adv_out(advance_load), .addr_out(addr), .lanes_out(ln), .data_out(wd));
	ssl_port dut_u (.sys_clk_in, .sys_rst_in, .clock_gate_n_in(gate_n),
		.select1_n_in(s[2]), .select2_in(s[1]), .select3_n_in(s[0]),
		.write_n_in(wr_n), .advance_load_in(advance_load), .addr_in(addr),
		.lane_wr_n_in(ln), .out_enable_n_in(oe_n), .sleep_req_in(sleep),
		.linear_order_n_in(order_n), .flow_select_n_in(flow_n),
		.data_in(wd), .data_out(rd), .data_oe_out(oe),
		.sleeping_out(slp), .wr_ready_out(rdy), .drop_out(drop));
	task automatic fail(input string m);
		$display("wrong value at %0t: %s", $time, m);
		num_errors++;
	endtask
	always @(posedge sys_clk_in) seen <= !gate_n && !sleep;
	// Held output after a gated edge must not retire a second note
	always @(negedge sys_clk_in) begin
		if (seen && oe === 4'hf) begin
			tests_run++;
			if (!exp_q.size() || rd !== exp_q.pop_front())
				fail("read data");
		end
	end
	task automatic op(input logic w, input logic ad, input logic [7:0] a,
		input logic [3:0] l);
		logic [35:0] d;
		d = {4'($random(seed)), 32'($random(seed))};
		for (int i = 0; i < 4; i++)
			if (w && !l[i]) mem_ref[a][9*i+:9] = d[9*i+:9];
		if (!w && !oe_n) exp_q.push_back(mem_ref[a]);
		mst_u.cmd(1'b0, 3'b010, !w, ad, ad ? ~a : a, l, d);
	endtask
	task automatic idle(input logic [7:0] a, input int n);
		for (int i = 0; i < n; i++)
			mst_u.cmd(1'b0, ds[i % 3], 1'b0, 1'b0, a, 4'h0, ~36'h0);
	endtask
	task automatic burst(input logic w, input logic [7:0] a);
		for (int k = 0; k < 5; k++) begin
			if (k == 2) mst_u.cmd(1'b1, 3'b010, 1'b0, 1'b0, a, 4'h0, ~36'h0);
			op(w, k != 0, {a[7:2], order_n ? a[1:0] ^ 2'(k)
				: a[1:0] + 2'(k)}, k == 1 ? 4'hf : k == 2 ? 4'h0
				: 4'($random(seed)));
		end
	endtask
	task automatic tally_and_finish();
		if (exp_q.size() != 0) fail("reads missing");
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_in);
		tests_run++;
		if (rd !== 36'h0 || {oe, slp, rdy, drop} !== 7'b0000010) fail("reset");
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 256; i++) op(1'b1, 1'b0, 8'(i), 4'h0);
		for (int m = 0; m < 4; m++) begin
			logic [7:0] a;
			a = 8'($random(seed));
			idle(a, 12);
			flow_n <= m[0];
			order_n <= m[1];
			idle(a, 2);
			burst(1'b1, a);
			op(1'b0, 1'b0, a ^ 8'h10, 4'h0);
			op(1'b1, 1'b0, a ^ 8'h20, 4'h5);
			idle(a, 12);
			burst(1'b0, a);
			op(1'b0, 1'b0, a ^ 8'h20, 4'h0);
			idle(a, 4);
			oe_n <= 1'b1;
			idle(a, 1);
			op(1'b0, 1'b0, a, 4'h0);
			idle(a, 4);
			oe_n <= 1'b0;
			sleep <= 1'b1;
			idle(a, 3);
			sleep <= 1'b0;
		end
		idle(8'h00, 8);
		tally_and_finish();
	end
	initial begin
		#100000;
		fail("timeout");
		tally_and_finish();
	end
endmodule
`default_nettype wire
